/* iqsh_defs.svh */
// Purpose: constants of the instrument query and status handler
// Assumes: plain register port, 125 MHz mclk
// Notes on behaviour
// - step query gives -1 when idle
// - jump count query gives -1 when idle
// - dc voltage over range answers 999.9
// - ac voltage over range answers 999
// - dc current over range answers 99.99
// - ac current over range answers 99.9
// - over range substitutes fixed reply value
// - memory selector accepts only 2 to 17
// - block transfer carries 2048 data bytes
// - reads stream the selected memory from the current pointer
// - clear loads sine, square, triangle shapes
// - byte status registers hold 0 to 255
// - operation group has four 15-bit registers
// - warning group has event and enable
// - overload group has four 15-bit registers
// - clear status empties all event registers
// - completion sets flag after pending work
// - completion query answers 1 when idle
// - wait holds further commands until done
// - single settings are 0 off, 1 on
// - self test returns 0 or code to 444
// - version is read only major.minor
// - sequencer state 0 idle 1 run 2 hold
`ifndef IQSH_DEFS_SVH
`define IQSH_DEFS_SVH
// register indices (byte address = 4 * index)
`define IQSH_A_STB 6'h00
`define IQSH_A_SRE 6'h01
`define IQSH_A_ESR 6'h02
`define IQSH_A_ESE 6'h03
`define IQSH_A_OPCOND 6'h04
`define IQSH_A_OPFILT 6'h05
`define IQSH_A_OPEV 6'h06
`define IQSH_A_OPMASK 6'h07
`define IQSH_A_WREV 6'h08
`define IQSH_A_WRMASK 6'h09
`define IQSH_A_OVCOND 6'h0A
`define IQSH_A_OVFILT 6'h0B
`define IQSH_A_OVEV 6'h0C
`define IQSH_A_OVMASK 6'h0D
`define IQSH_A_CMD 6'h0E
`define IQSH_A_OPCQ 6'h0F
`define IQSH_A_SET 6'h10
`define IQSH_A_TST 6'h11
`define IQSH_A_FWVER 6'h12
`define IQSH_A_SEQ 6'h13
`define IQSH_A_STEP 6'h14
`define IQSH_A_JUMP 6'h15
`define IQSH_A_MDCV 6'h16
`define IQSH_A_ACVM 6'h17
`define IQSH_A_MDCI 6'h18
`define IQSH_A_MACI 6'h19
`define IQSH_A_WSEL 6'h1A
`define IQSH_A_WDAT 6'h1B
`define IQSH_A_WCNT 6'h1C
// command register bits
`define IQSH_CMD_CLS 0
`define IQSH_CMD_OPC 1
`define IQSH_CMD_WAI 2
`define IQSH_CMD_WCLR 3
// status byte and event bits
`define IQSH_ESR_OPC 0
`define IQSH_STB_WRN 0
`define IQSH_STB_OVL 1
`define IQSH_STB_ESB 5
`define IQSH_STB_MSS 6
`define IQSH_STB_OPR 7
// measurement scaled limits and over range replies
`define IQSH_DCV_MAX 16'sd2000
`define IQSH_DCV_OVR 16'sd9999
`define IQSH_ACV_MAX 16'sd400
`define IQSH_ACV_OVR 16'sd999
`define IQSH_DCI_MAX 16'sd2000
`define IQSH_DCI_OVR 16'sd9999
`define IQSH_ACI_MAX 16'sd400
`define IQSH_ACI_OVR 16'sd999
// waveform memory, self test limit and version
`define IQSH_WSEL_MIN 5'd2
`define IQSH_WSEL_MAX 5'd17
`define IQSH_WBYTES 12'd2048
`define IQSH_TST_MAX 16'd444
`define IQSH_VERSION 16'h0100
`endif

/* iqsh_pkg.sv */
// Purpose: types of the query and status handler
// Assumes: constants live in iqsh_defs.svh
// Notes: none
`default_nettype none
package iqsh_pkg;
	typedef enum logic [1:0] {IQSH_IDLE, IQSH_RUN, IQSH_HOLD} iqsh_seq_e;
	typedef enum logic [1:0] {IQSH_W_IDLE, IQSH_W_FILL} iqsh_wst_e;
endpackage
`default_nettype wire

/* iqsh_group.sv */
// Purpose: one condition / transition filter / event / enable group
// Assumes: condition comes from same-clock logic
// Notes: set beats clear on the same cycle
`timescale 1ns/1ps
`default_nettype none
module iqsh_group #(
	parameter int W = 15
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] cond,
	input wire logic [W-1:0] ptr_filt,
	input wire logic [W-1:0] ntr_filt,
	input wire logic [W-1:0] enable,
	input wire logic clear,
	output logic [W-1:0] event_bits,
	output logic summary
);
	typedef struct packed
	{
		logic [W-1:0] prev;
		logic [W-1:0] ev;
	} iqsh_grp_s;
	iqsh_grp_s st, next_st;
	logic [W-1:0] hit;
	// edge detect through the filters
	always_comb
	begin
		next_st = st;
		hit = (cond & ~st.prev & ptr_filt) | (~cond & st.prev & ntr_filt);
		next_st.prev = cond;
		// read clears, new edges still win
		next_st.ev = (clear ? '0 : st.ev) | hit;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end
	assign event_bits = st.ev;
	assign summary = |(st.ev & enable);
	// rising condition latches when filter allows
	property p_grp_latch;
		@(posedge mclk) disable iff (!rst_n)
		(cond[0] && !st.prev[0] && ptr_filt[0]) |=> st.ev[0];
	endproperty
	a_grp_latch: assert property (p_grp_latch) else $error("event bit not latched");
	// clear empties unless a new edge
	property p_grp_clear;
		@(posedge mclk) disable iff (!rst_n)
		(clear && hit == '0) |=> st.ev == '0;
	endproperty
	a_grp_clear: assert property (p_grp_clear) else $error("event bits not cleared");
endmodule
`default_nettype wire

/* iqsh_meas.sv */
// Purpose: passes a scaled measurement to its reply, or the over range code when outside its limits
// Assumes: value is a signed scaled count
// Notes: output registered
`timescale 1ns/1ps
`default_nettype none
module iqsh_meas #(
	parameter logic signed [15:0] MAXV = 16'sd2000,
	parameter logic signed [15:0] MINV = -16'sd2000,
	parameter logic signed [15:0] OVR = 16'sd9999
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic signed [15:0] raw,
	output logic signed [15:0] reply
);
	typedef struct packed
	{
		logic signed [15:0] r;
	} iqsh_meas_s;
	iqsh_meas_s st, next_st;
	always_comb
	begin
		next_st = st;
		if (raw > MAXV || raw < MINV)
			next_st.r = OVR;
		else
			next_st.r = raw;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end
	assign reply = st.r;
	property p_meas_ovr;
		@(posedge mclk) disable iff (!rst_n)
		(raw > MAXV) |=> reply == OVR;
	endproperty
	a_meas_ovr: assert property (p_meas_ovr) else $error("over range reply missing");
endmodule
`default_nettype wire

/* iqsh_top.sv */
// Purpose: status registers, overlap commands, queries and waveform memory port
// Assumes: host reaches registers on a plain strobe port; measurements in scaled counts
// Notes: read data stand one cycle after the read strobe only
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "iqsh_defs.svh"
module iqsh_top #(
	parameter int MEM_BYTES = 2048,
	parameter logic [15:0] VERSION = `IQSH_VERSION
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [5:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [1:0] seq_state,
	input wire logic [7:0] seq_step,
	input wire logic [9:0] seq_jumps,
	input wire logic op_pending,
	input wire logic [14:0] op_cond,
	input wire logic [14:0] ovl_cond,
	input wire logic [14:0] warn_set,
	input wire logic [7:0] esr_set,
	input wire logic [15:0] tst_result,
	input wire logic signed [15:0] dcv_raw,
	input wire logic signed [15:0] acv_raw,
	input wire logic signed [15:0] dci_raw,
	input wire logic signed [15:0] aci_raw,
	output logic cmd_hold,
	output logic beeper_setting,
	output logic reply_header,
	output logic poweron_output_state,
	output logic poweron_calibrator_state,
	output logic external_control_input_enable,
	output logic [7:0] wave_sample,
	output logic wave_sample_valid
);
	// elaboration check: the memory map is fixed at 16 blocks of 2048 bytes
	if (MEM_BYTES != 2048)
	begin : g_mem_chk
		$error("memory size must be 2048 bytes");
	end
	typedef struct packed
	{
		logic [7:0] sre;
		logic [7:0] esr;
		logic [7:0] ese;
		logic [14:0] op_filt;
		logic [14:0] op_mask;
		logic [14:0] wrev;
		logic [14:0] wr_mask;
		logic [14:0] ov_filt;
		logic [14:0] ov_mask;
		logic [4:0] wsel;
		logic [10:0] wptr;
		logic [11:0] wcnt;
		logic opc_armed;
		logic wai;
		logic [4:0] sets;
		logic clr_busy;
		logic [14:0] clr_idx;
		logic [31:0] rdata;
		logic wvalid;
		logic [7:0] wsample;
	} iqsh_top_s;
	iqsh_top_s st, next_st;
	logic [7:0] wmem [0:16*2048-1];
	logic [7:0] mem_q;
	logic [14:0] opev, ovev;
	logic op_sum, ov_sum;
	logic signed [15:0] dcv_r, acv_r, dci_r, aci_r;
	logic [7:0] stb;
	logic clr_op, clr_ov;
	logic wr_cmd, wr_mem, mem_we;
	logic [14:0] mem_addr;
	logic [7:0] mem_d;
	// word address for a memory index 2..17 and byte offset
	function automatic logic [14:0] iqsh_maddr(input logic [4:0] sel, input logic [10:0] ofs);
		logic [3:0] m;
		m = 4'(sel - `IQSH_WSEL_MIN);
		return {m, ofs};
	endfunction
	// shape byte for a memory during clear
	function automatic logic [7:0] iqsh_shape(input logic [3:0] m, input logic [10:0] i);
		logic [7:0] ph;
		logic [7:0] tri_v;
		ph = i[10:3];
		tri_v = ph[7] ? ~{ph[6:0], 1'b0} : {ph[6:0], 1'b0};
		// sine 1-8, square 9-12, triangle 13-16
		if (m < 4'd8)
			return (ph[7] ? 8'h80 - {1'b0, tri_v[7:1]} : 8'h80 + {1'b0, tri_v[7:1]});
		else if (m < 4'd12)
			return ph[7] ? 8'h00 : 8'hFF;
		else
			return tri_v;
	endfunction
	iqsh_group #(.W(15)) u_op (
		.mclk(mclk), .rst_n(rst_n), .cond(op_cond), .ptr_filt(st.op_filt), .ntr_filt(15'h0000),
		.enable(st.op_mask), .clear(clr_op), .event_bits(opev), .summary(op_sum));
	iqsh_group #(.W(15)) u_ov (
		.mclk(mclk), .rst_n(rst_n), .cond(ovl_cond), .ptr_filt(st.ov_filt), .ntr_filt(15'h0000),
		.enable(st.ov_mask), .clear(clr_ov), .event_bits(ovev), .summary(ov_sum));
	iqsh_meas #(.MAXV(`IQSH_DCV_MAX), .MINV(-`IQSH_DCV_MAX), .OVR(`IQSH_DCV_OVR)) u_dcv (
		.mclk(mclk), .rst_n(rst_n), .raw(dcv_raw), .reply(dcv_r));
	iqsh_meas #(.MAXV(`IQSH_ACV_MAX), .MINV(16'sd0), .OVR(`IQSH_ACV_OVR)) u_acv (
		.mclk(mclk), .rst_n(rst_n), .raw(acv_raw), .reply(acv_r));
	iqsh_meas #(.MAXV(`IQSH_DCI_MAX), .MINV(-`IQSH_DCI_MAX), .OVR(`IQSH_DCI_OVR)) u_dci (
		.mclk(mclk), .rst_n(rst_n), .raw(dci_raw), .reply(dci_r));
	iqsh_meas #(.MAXV(`IQSH_ACI_MAX), .MINV(16'sd0), .OVR(`IQSH_ACI_OVR)) u_aci (
		.mclk(mclk), .rst_n(rst_n), .raw(aci_raw), .reply(aci_r));
	// commands and clears stall while a wait or the memory clear sweep is pending
	assign cmd_hold = st.wai | st.clr_busy;
	assign wr_cmd = wr && addr == `IQSH_A_CMD && !cmd_hold;
	assign wr_mem = wr && addr == `IQSH_A_WDAT && !st.clr_busy && st.wcnt != '0;
	// clear status also empties the group event registers
	assign clr_op = (rd && addr == `IQSH_A_OPEV) || (wr_cmd && wdata[`IQSH_CMD_CLS]);
	assign clr_ov = (rd && addr == `IQSH_A_OVEV) || (wr_cmd && wdata[`IQSH_CMD_CLS]);
	// status byte summary, master bit from enabled sources
	always_comb
	begin
		stb = '0;
		stb[`IQSH_STB_WRN] = |(st.wrev & st.wr_mask);
		stb[`IQSH_STB_OVL] = ov_sum;
		stb[`IQSH_STB_ESB] = |(st.esr & st.ese);
		stb[`IQSH_STB_OPR] = op_sum;
		stb[`IQSH_STB_MSS] = |(stb & st.sre & 8'hBF);
	end
	// one shared memory port: clear sweep has it first, else host writes, else reads
	always_comb
	begin
		mem_we = st.clr_busy | wr_mem;
		mem_addr = st.clr_busy ? st.clr_idx : iqsh_maddr(st.wsel, st.wptr);
		mem_d = st.clr_busy ? iqsh_shape(st.clr_idx[14:11], st.clr_idx[10:0]) : wdata[7:0];
	end
	always_ff @(posedge mclk)
	begin
		if (mem_we)
			wmem[mem_addr] <= mem_d;
		mem_q <= wmem[mem_addr];
	end
	// register file and command sequencing
	always_comb
	begin
		next_st = st;
		next_st.rdata = '0;
		next_st.wvalid = 1'b0;
		// disarm once work finishes; the flag itself is set last
		if (st.opc_armed && !op_pending)
			next_st.opc_armed = 1'b0;
		// wait releases when nothing is pending
		if (st.wai && !op_pending)
			next_st.wai = 1'b0;
		if (st.clr_busy)
		begin
			next_st.clr_idx = 15'(st.clr_idx + 15'd1);
			if (st.clr_idx == '1)
				next_st.clr_busy = 1'b0;
		end
		if (rd)
		begin
			unique case (addr)
				`IQSH_A_STB: next_st.rdata = {24'h0, stb};
				`IQSH_A_SRE: next_st.rdata = {24'h0, st.sre};
				`IQSH_A_ESR: next_st.rdata = {24'h0, st.esr};
				`IQSH_A_ESE: next_st.rdata = {24'h0, st.ese};
				`IQSH_A_OPCOND: next_st.rdata = {17'h0, op_cond};
				`IQSH_A_OPFILT: next_st.rdata = {17'h0, st.op_filt};
				`IQSH_A_OPEV: next_st.rdata = {17'h0, opev};
				`IQSH_A_OPMASK: next_st.rdata = {17'h0, st.op_mask};
				`IQSH_A_WREV: next_st.rdata = {17'h0, st.wrev};
				`IQSH_A_WRMASK: next_st.rdata = {17'h0, st.wr_mask};
				`IQSH_A_OVCOND: next_st.rdata = {17'h0, ovl_cond};
				`IQSH_A_OVFILT: next_st.rdata = {17'h0, st.ov_filt};
				`IQSH_A_OVEV: next_st.rdata = {17'h0, ovev};
				`IQSH_A_OVMASK: next_st.rdata = {17'h0, st.ov_mask};
				`IQSH_A_CMD: next_st.rdata = {29'h0, st.wai, st.opc_armed, st.clr_busy};
				// answers 1 only with nothing pending
				`IQSH_A_OPCQ: next_st.rdata = {31'h0, !op_pending && !st.clr_busy};
				`IQSH_A_SET: next_st.rdata = {27'h0, st.sets};
				// self test code, clipped to 444
				`IQSH_A_TST: next_st.rdata = {16'h0, tst_result > `IQSH_TST_MAX ? `IQSH_TST_MAX : tst_result};
				`IQSH_A_FWVER: next_st.rdata = {16'h0, VERSION};
				`IQSH_A_SEQ: next_st.rdata = {30'h0, seq_state};
				// idle or step 0 reads -1
				`IQSH_A_STEP: next_st.rdata = (seq_state == iqsh_pkg::IQSH_IDLE || seq_step == 8'h00) ?
					32'hFFFFFFFF : {24'h0, seq_step};
				`IQSH_A_JUMP: next_st.rdata = (seq_state == iqsh_pkg::IQSH_IDLE) ? 32'hFFFFFFFF : {22'h0, seq_jumps};
				`IQSH_A_MDCV: next_st.rdata = {{16{dcv_r[15]}}, dcv_r};
				`IQSH_A_ACVM: next_st.rdata = {{16{acv_r[15]}}, acv_r};
				`IQSH_A_MDCI: next_st.rdata = {{16{dci_r[15]}}, dci_r};
				`IQSH_A_MACI: next_st.rdata = {{16{aci_r[15]}}, aci_r};
				`IQSH_A_WSEL: next_st.rdata = {27'h0, st.wsel};
				`IQSH_A_WCNT: next_st.rdata = {20'h0, st.wcnt};
				default: next_st.rdata = '0;
			endcase
			if (addr == `IQSH_A_ESR)
				next_st.esr = '0;
			if (addr == `IQSH_A_WREV)
				next_st.wrev = '0;
		end
		if (wr)
		begin
			unique case (addr)
				`IQSH_A_SRE: next_st.sre = wdata[7:0];
				`IQSH_A_ESE: next_st.ese = wdata[7:0];
				`IQSH_A_OPFILT: next_st.op_filt = wdata[14:0];
				`IQSH_A_OPMASK: next_st.op_mask = wdata[14:0];
				`IQSH_A_WRMASK: next_st.wr_mask = wdata[14:0];
				`IQSH_A_OVFILT: next_st.ov_filt = wdata[14:0];
				`IQSH_A_OVMASK: next_st.ov_mask = wdata[14:0];
				`IQSH_A_SET: next_st.sets = wdata[4:0];
				// selector takes only 2 to 17, and restarts the block
				`IQSH_A_WSEL:
				begin
					if (wdata[4:0] >= `IQSH_WSEL_MIN && wdata[4:0] <= `IQSH_WSEL_MAX && wdata[31:5] == '0)
					begin
						next_st.wsel = wdata[4:0];
						next_st.wptr = '0;
						next_st.wcnt = `IQSH_WBYTES;
					end
				end
				default: ;
			endcase
		end
		// a block is 2048 bytes, byte by byte
		if (wr_mem)
		begin
			next_st.wptr = 11'(st.wptr + 11'd1);
			next_st.wcnt = 12'(st.wcnt - 12'd1);
		end
		// reads stream the selected memory from the current pointer, wrapping at 2048
		if (rd && addr == `IQSH_A_WDAT && !st.clr_busy && !wr_mem)
		begin
			next_st.wptr = 11'(st.wptr + 11'd1);
			next_st.wvalid = 1'b1;
		end
		if (wr_cmd)
		begin
			if (wdata[`IQSH_CMD_CLS])
			begin
				next_st.esr = '0;
				next_st.wrev = '0;
			end
			if (wdata[`IQSH_CMD_OPC])
				next_st.opc_armed = 1'b1;
			if (wdata[`IQSH_CMD_WAI])
				next_st.wai = op_pending;
			if (wdata[`IQSH_CMD_WCLR])
			begin
				next_st.clr_busy = 1'b1;
				next_st.clr_idx = '0;
			end
		end
		// hardware sets win over any clear this cycle
		next_st.esr = next_st.esr | esr_set;
		next_st.wrev = next_st.wrev | warn_set;
		// completion flag after the read and status clears, so it is never lost
		if (st.opc_armed && !op_pending)
			next_st.esr[`IQSH_ESR_OPC] = 1'b1;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.wsel <= `IQSH_WSEL_MIN;
			st.wcnt <= `IQSH_WBYTES;
		end
		else
			st <= next_st;
	end
	assign rdata = st.wvalid ? {24'h0, mem_q} : st.rdata;
	assign wave_sample = mem_q;
	assign wave_sample_valid = st.wvalid;
	assign {external_control_input_enable, poweron_calibrator_state, poweron_output_state, reply_header,
		beeper_setting} = st.sets;
	// idle step query answers -1 next cycle
	property p_step_idle;
		@(posedge mclk) disable iff (!rst_n)
		(rd && addr == `IQSH_A_STEP && seq_state == 2'd0) |=> rdata == 32'hFFFFFFFF;
	endproperty
	a_step_idle: assert property (p_step_idle) else $error("step query not -1 when idle");
	property p_jump_idle;
		@(posedge mclk) disable iff (!rst_n)
		(rd && addr == `IQSH_A_JUMP && seq_state == 2'd0) |=> rdata == 32'hFFFFFFFF;
	endproperty
	a_jump_idle: assert property (p_jump_idle) else $error("jump query not -1 when idle");
	property p_wsel_range;
		@(posedge mclk) disable iff (!rst_n)
		st.wsel >= 5'd2 && st.wsel <= 5'd17;
	endproperty
	a_wsel_range: assert property (p_wsel_range) else $error("selector out of range");
	sequence s_opc_arm;
		wr_cmd && wdata[1];
	endsequence
	property p_opc_flag;
		@(posedge mclk) disable iff (!rst_n)
		s_opc_arm ##1 !op_pending |=> st.esr[0];
	endproperty
	a_opc_flag: assert property (p_opc_flag) else $error("completion flag missing");
	property p_opcq;
		@(posedge mclk) disable iff (!rst_n)
		(rd && addr == `IQSH_A_OPCQ && op_pending) |=> rdata == 32'h0;
	endproperty
	a_opcq: assert property (p_opcq) else $error("completion query 1 while pending");
	property p_wai_hold;
		@(posedge mclk) disable iff (!rst_n)
		(wr_cmd && wdata[2] && op_pending) |=> cmd_hold;
	endproperty
	a_wai_hold: assert property (p_wai_hold) else $error("wait did not hold commands");
	property p_cls;
		@(posedge mclk) disable iff (!rst_n)
		(wr_cmd && wdata[0] && esr_set == 8'h0 && !(st.opc_armed && !op_pending)) |=> st.esr == 8'h0;
	endproperty
	a_cls: assert property (p_cls) else $error("clear status left events");
	property p_tst;
		@(posedge mclk) disable iff (!rst_n)
		rd && addr == `IQSH_A_TST |=> rdata <= 32'd444;
	endproperty
	a_tst: assert property (p_tst) else $error("self test code above 444");
endmodule
`default_nettype wire

/* iqsh_host.sv */
// Purpose: host side of the register port, one strobe per access
// Assumes: read data stand only in the cycle after the read strobe
// Notes: released write data show the inverse so stale values are never trusted
`timescale 1ns/1ps
`default_nettype none
`include "iqsh_defs.svh"
module iqsh_host (
	input wire logic mclk,
	input wire logic [31:0] rdata,
	output logic [5:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd
);
	// idle bus at time zero
	initial
	begin
		addr = 6'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
	end

	// one write cycle, strobe dropped at the next edge
	task automatic put(input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask

	// one read cycle; data taken at the edge after the strobe
	task automatic get(input logic [5:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		d = rdata;
	endtask

	// select first, then a full block
	task automatic load(input logic [7:0] sel, input logic [7:0] base);
		put(`IQSH_A_WSEL, {24'h0, sel});
		for (int i = 0; i < 2048; i++)
			put(`IQSH_A_WDAT, {24'h0, 8'(i) ^ base});
	endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench for the query and status handler
// Assumes: host model drives the register port
// Notes: memory clear sweep dominates the run time
`timescale 1ns/1ps
`default_nettype none
`include "iqsh_defs.svh"
module testbench;
	logic mclk;
	logic rst_n;
	logic [5:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic wr;
	logic rd;
	logic [1:0] seq_state;
	logic [7:0] seq_step;
	logic [9:0] seq_jumps;
	logic op_pending;
	logic [14:0] cond;
	logic [14:0] warn_set;
	logic [7:0] esr_set;
	logic [15:0] tst_result;
	logic signed [15:0] raw [4];
	logic [4:0] sets;
	logic cmd_hold;
	logic [7:0] wsamp;
	logic wsv;
	int err_total;
	int n_compared;
	int cyc;

	iqsh_top u_dut (
		.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.seq_state(seq_state), .seq_step(seq_step), .seq_jumps(seq_jumps), .op_pending(op_pending),
		.op_cond(cond), .ovl_cond(cond), .warn_set(warn_set), .esr_set(esr_set), .tst_result(tst_result),
		.dcv_raw(raw[0]), .acv_raw(raw[1]), .dci_raw(raw[2]), .aci_raw(raw[3]), .cmd_hold(cmd_hold),
		.beeper_setting(sets[0]), .reply_header(sets[1]), .poweron_output_state(sets[2]),
		.poweron_calibrator_state(sets[3]), .external_control_input_enable(sets[4]),
		.wave_sample(wsamp), .wave_sample_valid(wsv)
	);
	iqsh_host u_host (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	// 125 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// hang guard, well above the clear sweep plus block traffic
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 100000)
		begin
			err_total++;
			test_done();
		end
	end

	task automatic test_done();
		if (err_total == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] v;
		u_host.get(a, v);
		chk($sformatf("reg %h", a), v & m, exp);
	endtask

	// bounded wait for the command gate to reopen
	task automatic wait_free();
		int n;
		n = 0;
		while (cmd_hold !== 1'b0 && n < 40000)
		begin
			@(posedge mclk);
			n++;
		end
		chk("cmd_hold", {31'h0, cmd_hold}, 32'h0);
	endtask

	task automatic pulse(input logic [7:0] e, input logic [14:0] w);
		@(posedge mclk);
		esr_set <= e;
		warn_set <= w;
		@(posedge mclk);
		esr_set <= 8'h00;
		warn_set <= 15'h0000;
	endtask

	task automatic t_misc();
		rc(`IQSH_A_WSEL, 32'hFF, 32'h2);
		rc(`IQSH_A_WCNT, 32'hFFFF, 32'h800);
		u_host.put(`IQSH_A_FWVER, 32'h0);
		rc(`IQSH_A_FWVER, 32'hFFFF, {16'h0, `IQSH_VERSION});
		@(posedge mclk);
		tst_result <= 16'h01BC;
		rc(`IQSH_A_TST, 32'hFFFF, 32'h1BC);
		for (int b = 0; b < 5; b++)
		begin
			u_host.put(`IQSH_A_SET, 32'h1 << b);
			#1;
			chk("settings", {27'h0, sets}, 32'h1 << b);
			rc(`IQSH_A_SET, 32'h1F, 32'h1 << b);
		end
	endtask

	task automatic t_seq();
		logic [31:0] e;
		for (int s = 0; s < 4; s++)
		begin
			@(posedge mclk);
			seq_state <= (s == 3) ? 2'h1 : 2'(s);
			seq_step <= (s == 3) ? 8'h00 : 8'h05;
			seq_jumps <= 10'h003;
			e = (s == 0 || s == 3) ? 32'hFFFF : 32'h5;
			rc(`IQSH_A_STEP, 32'hFFFF, e);
			rc(`IQSH_A_SEQ, 32'h3, (s == 3) ? 32'h1 : 32'(s));
			rc(`IQSH_A_JUMP, 32'hFFFF, (s == 0) ? 32'hFFFF : 32'h3);
		end
	endtask

	task automatic t_meas();
		logic [15:0] mx [4] = '{16'h07D0, 16'h0190, 16'h07D0, 16'h0190};
		logic [15:0] ov [4] = '{16'h270F, 16'h03E7, 16'h270F, 16'h03E7};
		logic [15:0] v;
		for (int k = 0; k < 4; k++)
		begin
			for (int c = 0; c < 3; c++)
			begin
				v = (c == 0) ? mx[k] : (c == 1) ? mx[k] + 16'h1 : (k % 2 ? 16'h0 : 16'h0 - mx[k]);
				@(posedge mclk);
				raw[k] <= v;
				rc(6'(`IQSH_A_MDCV + k), 32'hFFFF, {16'h0, (c == 1) ? ov[k] : v});
			end
		end
	endtask

	task automatic t_grp();
		logic [5:0] tf [2] = '{`IQSH_A_OPFILT, `IQSH_A_OVFILT};
		logic [5:0] ev [2] = '{`IQSH_A_OPEV, `IQSH_A_OVEV};
		logic [5:0] ee [2] = '{`IQSH_A_OPMASK, `IQSH_A_OVMASK};
		logic [5:0] cr [2] = '{`IQSH_A_OPCOND, `IQSH_A_OVCOND};
		logic [31:0] sb [2] = '{32'h80, 32'h02};
		for (int g = 0; g < 2; g++)
		begin
			@(posedge mclk);
			cond <= 15'h0000;
			u_host.put(`IQSH_A_CMD, 32'h1);
			u_host.put(tf[g], 32'hFFFF);
			rc(tf[g], 32'hFFFFFFFF, 32'h7FFF);
			@(posedge mclk);
			cond <= 15'h0004;
			rc(cr[g], 32'hFFFFFFFF, 32'h4);
			u_host.put(ee[g], 32'h4);
			rc(`IQSH_A_STB, sb[g], sb[g]);
			rc(ev[g], 32'hFFFFFFFF, 32'h4);
			rc(ev[g], 32'hFFFFFFFF, 32'h0);
			rc(`IQSH_A_STB, sb[g], 32'h0);
			@(posedge mclk);
			cond <= 15'h0000;
			rc(cr[g], 32'hFFFFFFFF, 32'h0);
			rc(ev[g], 32'hFFFFFFFF, 32'h0);
		end
	endtask

	task automatic t_esr();
		pulse(8'h08, 15'h0002);
		u_host.put(`IQSH_A_ESE, 32'h1FF);
		u_host.put(`IQSH_A_SRE, 32'h1FF);
		u_host.put(`IQSH_A_WRMASK, 32'h2);
		rc(`IQSH_A_ESE, 32'hFFFFFFFF, 32'hFF);
		rc(`IQSH_A_SRE, 32'hFFFFFFFF, 32'hFF);
		rc(`IQSH_A_STB, 32'h21, 32'h21);
		rc(`IQSH_A_WREV, 32'hFFFFFFFF, 32'h2);
		rc(`IQSH_A_WREV, 32'hFFFFFFFF, 32'h0);
		u_host.put(`IQSH_A_CMD, 32'h1);
		rc(`IQSH_A_ESR, 32'hFFFFFFFF, 32'h0);
		rc(`IQSH_A_STB, 32'h21, 32'h0);
		pulse(8'h10, 15'h0000);
		rc(`IQSH_A_ESR, 32'hFFFFFFFF, 32'h10);
		rc(`IQSH_A_ESR, 32'hFFFFFFFF, 32'h0);
	endtask

	// completion flag and wait gate while an operation is pending
	task automatic t_opc();
		@(posedge mclk);
		op_pending <= 1'b1;
		u_host.put(`IQSH_A_CMD, 32'h2);
		rc(`IQSH_A_OPCQ, 32'h1, 32'h0);
		rc(`IQSH_A_ESR, 32'h1, 32'h0);
		pulse(8'h04, 15'h0000);
		u_host.put(`IQSH_A_CMD, 32'h4);
		@(posedge mclk);
		chk("cmd_hold", {31'h0, cmd_hold}, 32'h1);
		u_host.put(`IQSH_A_CMD, 32'h1);
		@(posedge mclk);
		op_pending <= 1'b0;
		wait_free();
		rc(`IQSH_A_OPCQ, 32'h1, 32'h1);
		rc(`IQSH_A_ESR, 32'h5, 32'h5);
		u_host.put(`IQSH_A_CMD, 32'h2);
		rc(`IQSH_A_ESR, 32'h1, 32'h1);
	endtask

	task automatic rdmem(input logic [7:0] base, output int same);
		logic [31:0] v;
		same = 0;
		u_host.put(`IQSH_A_WSEL, 32'h11);
		for (int i = 0; i < 2048; i++)
		begin
			u_host.get(`IQSH_A_WDAT, v);
			same += (v[7:0] === (8'(i) ^ base)) ? 1 : 0;
			chk("wave sample", {23'h0, wsv, wsamp}, {24'h1, v[7:0]});
		end
	endtask

	task automatic t_wave();
		int same;
		u_host.put(`IQSH_A_WSEL, 32'h1);
		rc(`IQSH_A_WSEL, 32'hFF, 32'h2);
		u_host.put(`IQSH_A_WSEL, 32'h12);
		rc(`IQSH_A_WSEL, 32'hFF, 32'h2);
		u_host.load(8'h11, 8'h5A);
		rc(`IQSH_A_WSEL, 32'hFF, 32'h11);
		rc(`IQSH_A_WCNT, 32'hFFFF, 32'h0);
		u_host.put(`IQSH_A_WDAT, 32'hA5);
		rdmem(8'h5A, same);
		chk("whole memory", same, 32'h800);
		u_host.put(`IQSH_A_CMD, 32'h8);
		@(posedge mclk);
		chk("cmd_hold", {31'h0, cmd_hold}, 32'h1);
		wait_free();
		rdmem(8'h5A, same);
		chk("cleared memory", same == 2048, 32'h0);
	endtask

	// mid-run reset must restore selector, count and the armed completion
	task automatic t_rst();
		@(posedge mclk);
		op_pending <= 1'b1;
		u_host.put(`IQSH_A_WDAT, 32'h0);
		u_host.put(`IQSH_A_CMD, 32'h2);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rc(`IQSH_A_WSEL, 32'hFF, 32'h2);
		rc(`IQSH_A_WCNT, 32'hFFFF, 32'h800);
		rc(`IQSH_A_CMD, 32'h7, 32'h0);
	endtask

	// reset, then one scenario after another
	initial
	begin
		rst_n = 1'b0;
		seq_state = 2'h0;
		seq_step = 8'h00;
		seq_jumps = 10'h000;
		op_pending = 1'b0;
		cond = 15'h0000;
		warn_set = 15'h0000;
		esr_set = 8'h00;
		tst_result = 16'h0000;
		for (int k = 0; k < 4; k++)
			raw[k] = 16'h0000;
		err_total = 0;
		n_compared = 0;
		cyc = 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		t_misc();
		t_seq();
		t_meas();
		t_grp();
		t_esr();
		t_opc();
		t_wave();
		t_rst();
		test_done();
	end
endmodule
`default_nettype wire
